// [core/anc_autoneg_core.sv]
// Auto-negotiation control, status and resolution core
`timescale 1ns/1ps
`default_nettype none
module anc_autoneg_core
  import anc_pkg::*;
#(
  parameter int BREAK_CYCLES = ANC_BREAK_CYCLES
) (
  input wire logic ref_clk,            // Core clock, 50 MHz
  input wire logic srst,               // Synchronous reset, active high
  input wire logic strapAnOff,         // Strap: negotiation disabled
  input wire logic [4:0] regAddr,      // Management register address
  input wire logic [15:0] regWrData,   // Management write data
  input wire logic regWrEn,            // Management write strobe
  input wire logic regRdEn,            // Management read strobe
  output logic [15:0] regRdData,       // Read data, one cycle later
  output logic regRdValid,             // Read data valid pulse
  input wire logic rxPageValid,        // Partner page received pulse
  input wire logic [15:0] rxPage,      // Partner page word
  input wire logic linkGood10,         // 10 Mb/s receiver link good
  input wire logic linkGood100,        // 100 Mb/s receiver link good
  input wire logic linkUp,             // Resolved link status
  input wire anc_gig_t localGig,       // Local gigabit abilities
  input wire anc_gig_t partnerGig,     // Partner gigabit abilities
  input wire logic seedWins,           // Tie-break for master choice
  output logic flpActive,              // Fast link pulse bursts on
  output logic dataEnable,             // Data transmission allowed
  output logic [15:0] txPage,          // Page word being sent
  output anc_mode_t mode,              // Negotiated operating mode
  output logic isMaster,               // Gigabit master selected
  output logic pauseValid              // Partner pause bits apply
);

  anc_state_t st_reg;
  anc_state_t st_next;

  // Highest common technology, gigabit first
  function automatic anc_mode_t resolveMode(input logic [15:0] loc,
                                            input logic [15:0] par,
                                            input anc_gig_t lg,
                                            input anc_gig_t pg);
    logic [15:0] c;
    c = loc & par;
    if (lg.gigFull && pg.gigFull) begin
      resolveMode = MODE_1000F;
    end else if (lg.gigHalf && pg.gigHalf) begin
      resolveMode = MODE_1000H;
    end else if (c[ANC_AB_100F_BIT]) begin
      resolveMode = MODE_100F;
    end else if (c[ANC_AB_100H_BIT]) begin
      resolveMode = MODE_100H;
    end else if (c[ANC_AB_10F_BIT]) begin
      resolveMode = MODE_10F;
    end else if (c[ANC_AB_10H_BIT]) begin
      resolveMode = MODE_10H;
    end else begin
      resolveMode = MODE_NONE;
    end
  endfunction

  function automatic logic isGig(input anc_mode_t m);
    isGig = (m == MODE_1000F) || (m == MODE_1000H);
  endfunction

  function automatic logic isFull(input anc_mode_t m);
    isFull = (m == MODE_1000F) || (m == MODE_100F) || (m == MODE_10F);
  endfunction

  // Multiport side wins; equal kinds fall back to the seed
  function automatic logic pickMaster(input anc_mode_t m,
                                      input anc_gig_t lg,
                                      input anc_gig_t pg,
                                      input logic seed);
    pickMaster = isGig(m) && ((lg.multiport && !pg.multiport) ||
                              ((lg.multiport == pg.multiport) && seed));
  endfunction

  always_comb begin
    logic faultSet;
    anc_mode_t m;
    st_next = st_reg;
    faultSet = 1'b0;
    m = MODE_NONE;
    st_next.rdValid = 1'b0;
    st_next.linkSeen = linkUp;
    if (!st_reg.anEnable) begin
      st_next.fsm = ST_DISABLED;
      st_next.flpActive = 1'b0;
      st_next.dataEnable = 1'b1;
      st_next.complete = 1'b0;
      st_next.ctrlRestart = 1'b0;
    end else if (st_reg.ctrlRestart) begin
      st_next.fsm = ST_BREAK;
      st_next.timer = 32'h0;
      st_next.flpActive = 1'b0;
      st_next.dataEnable = 1'b0;
      st_next.ctrlRestart = 1'b0;
      st_next.complete = 1'b0;
      st_next.pauseValid = 1'b0;
      st_next.isMaster = 1'b0;
      st_next.mode = MODE_NONE;
    end else begin
      case (st_reg.fsm)
        ST_DISABLED: begin
          st_next.fsm = ST_BREAK;
          st_next.timer = 32'h0;
          st_next.dataEnable = 1'b0;
        end
        ST_BREAK: begin
          st_next.timer = st_reg.timer + 32'h1;
          if (st_reg.timer >= 32'(BREAK_CYCLES - 1)) begin
            st_next.fsm = ST_ABILITY;
            st_next.flpActive = 1'b1;
          end
        end
        ST_ABILITY: begin
          // pause bits go out in the base page
          st_next.txPage = st_reg.advert;
          if (rxPageValid) begin
            st_next.partner = rxPage;
            st_next.expAble = 1'b1;
            st_next.expPage = 1'b1;
            st_next.parMode = 1'b0;
            if (st_reg.advert[ANC_ADV_NP_BIT] && rxPage[ANC_ADV_NP_BIT]) begin
              st_next.fsm = ST_NEXTPG;
              st_next.txPage = st_reg.nextPage;
            end else begin
              m = resolveMode(st_reg.advert, rxPage, localGig, partnerGig);
              st_next.mode = m;
              st_next.isMaster = pickMaster(m, localGig, partnerGig, seedWins);
              st_next.pauseValid = isFull(m);
              st_next.fsm = ST_COMPLETE;
            end
          end else if (linkGood10 && linkGood100) begin
            faultSet = 1'b1;
          end else if (linkGood10 || linkGood100) begin
            st_next.partner = 16'h0;
            st_next.partner[4:0] = ANC_SELECTOR;
            st_next.partner[ANC_AB_100H_BIT] = linkGood100;
            st_next.partner[ANC_AB_10H_BIT] = linkGood10;
            st_next.expAble = 1'b0;
            st_next.parMode = 1'b1;
            st_next.mode = linkGood100 ? MODE_100H : MODE_10H;
            st_next.isMaster = 1'b0;
            st_next.pauseValid = 1'b0;
            st_next.fsm = ST_COMPLETE;
          end
        end
        ST_NEXTPG: begin
          st_next.txPage = st_reg.nextPage;
          if (rxPageValid && st_reg.npLoaded) begin
            st_next.npLoaded = 1'b0;
            st_next.expPage = 1'b1;
            if (!st_reg.nextPage[ANC_ADV_NP_BIT] &&
                !rxPage[ANC_ADV_NP_BIT]) begin
              m = resolveMode(st_reg.advert, st_reg.partner, localGig,
                              partnerGig);
              st_next.mode = m;
              st_next.isMaster = pickMaster(m, localGig, partnerGig, seedWins);
              st_next.pauseValid = isFull(m);
              st_next.fsm = ST_COMPLETE;
            end
          end
        end
        ST_COMPLETE: begin
          st_next.flpActive = 1'b0;
          st_next.dataEnable = 1'b1;
          st_next.complete = 1'b1;
          if (!linkUp && st_reg.complete) begin
            st_next.fsm = ST_ABILITY;
            st_next.flpActive = 1'b1;
            st_next.dataEnable = 1'b0;
            st_next.complete = 1'b0;
            st_next.pauseValid = 1'b0;
            st_next.isMaster = 1'b0;
            st_next.mode = MODE_NONE;
            faultSet = st_reg.parMode;
          end
        end
        default: begin
          st_next.fsm = ST_DISABLED;
        end
      endcase
    end
    if (faultSet) begin
      st_next.parFault = 1'b1;
    end
    if (regRdEn) begin
      st_next.rdValid = 1'b1;
      case (regAddr)
        ANC_ADDR_CTRL: begin
          st_next.rdData = 16'h0;
          st_next.rdData[ANC_CTRL_EN_BIT] = st_reg.anEnable;
          st_next.rdData[ANC_CTRL_RESTART_BIT] = st_reg.ctrlRestart;
        end
        ANC_ADDR_STAT: begin
          st_next.rdData = 16'h0;
          st_next.rdData[ANC_STAT_DONE_BIT] = st_reg.complete;
          st_next.rdData[ANC_STAT_ABLE_BIT] = !st_reg.strapOff;
          st_next.rdData[ANC_STAT_LINK_BIT] = st_reg.linkSeen;
        end
        ANC_ADDR_ADV: st_next.rdData = st_reg.advert;
        ANC_ADDR_PART: st_next.rdData = st_reg.partner;
        ANC_ADDR_EXP: begin
          st_next.rdData = 16'h0;
          st_next.rdData[ANC_EXP_ABLE_BIT] = st_reg.expAble;
          st_next.rdData[ANC_EXP_PAGE_BIT] = st_reg.expPage;
          st_next.rdData[ANC_EXP_NPABLE_BIT] = 1'b1;
          st_next.rdData[ANC_EXP_FAULT_BIT] = st_reg.parFault;
          // Clear on read; a new event in this cycle wins
          st_next.parFault = faultSet;
          st_next.expPage = rxPageValid && (st_reg.fsm == ST_ABILITY ||
                                            st_reg.fsm == ST_NEXTPG);
        end
        ANC_ADDR_NPTX: st_next.rdData = st_reg.nextPage;
        default: st_next.rdData = 16'h0;
      endcase
    end
    if (regWrEn) begin
      case (regAddr)
        ANC_ADDR_CTRL: begin
          st_next.anEnable = regWrData[ANC_CTRL_EN_BIT] && !st_reg.strapOff;
          st_next.ctrlRestart = st_next.anEnable &&
            (regWrData[ANC_CTRL_RESTART_BIT] || !st_reg.anEnable);
        end
        ANC_ADDR_ADV: st_next.advert = regWrData;
        ANC_ADDR_NPTX: begin
          st_next.nextPage = regWrData;
          st_next.npLoaded = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.fsm <= ST_DISABLED;
      st_reg.mode <= MODE_NONE;
      st_reg.advert <= ANC_ADV_RESET;
      st_reg.nextPage <= ANC_NPTX_RESET;
      st_reg.dataEnable <= 1'b1;
      st_reg.strapOff <= strapAnOff;
      st_reg.anEnable <= !strapAnOff;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regRdData = st_reg.rdData;
  assign regRdValid = st_reg.rdValid;
  assign flpActive = st_reg.flpActive;
  assign dataEnable = st_reg.dataEnable;
  assign txPage = st_reg.txPage;
  assign mode = st_reg.mode;
  assign isMaster = st_reg.isMaster;
  assign pauseValid = st_reg.pauseValid;

  a_restart_accept: assert property (@(posedge ref_clk)
    disable iff (srst)
    st_reg.ctrlRestart && st_reg.anEnable |=> st_reg.fsm == ST_BREAK &&
    !st_reg.ctrlRestart) else $error("restart not accepted");
  a_break_silent: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg.fsm == ST_BREAK |-> !flpActive && !dataEnable && !st_reg.complete)
    else $error("activity during break link");
  a_break_bound: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg.fsm == ST_BREAK && st_reg.timer >= 32'(BREAK_CYCLES - 1) &&
    st_reg.anEnable && !st_reg.ctrlRestart |=> st_reg.fsm == ST_ABILITY &&
    flpActive) else $error("bursts not resumed after break");
  a_strap_lock: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg.strapOff |-> !st_reg.anEnable) else $error("strap enable leak");
  a_parallel_regs: assert property (@(posedge ref_clk)
    disable iff (srst)
    st_reg.fsm == ST_ABILITY && st_reg.anEnable && !st_reg.ctrlRestart &&
    !rxPageValid && (linkGood10 ^ linkGood100) |=>
    st_reg.partner[4:0] == ANC_SELECTOR && !st_reg.expAble &&
    st_reg.fsm == ST_COMPLETE ##1 st_reg.complete)
    else $error("parallel detect registers wrong");
  a_link_loss: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg.fsm == ST_COMPLETE && st_reg.complete && !linkUp &&
    st_reg.anEnable && !st_reg.ctrlRestart |=> st_reg.fsm == ST_ABILITY &&
    !st_reg.complete) else $error("no resume after link loss");
  a_pause_gate: assert property (@(posedge ref_clk) disable iff (srst)
    pauseValid |-> isFull(mode)) else $error("pause without full duplex");
  a_gig_master: assert property (@(posedge ref_clk) disable iff (srst)
    isMaster |-> isGig(mode)) else $error("master outside gigabit");
  a_advert_pause: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg.fsm == ST_ABILITY && $past(st_reg.fsm) == ST_ABILITY |->
    txPage[ANC_ADV_ASYM_BIT:ANC_ADV_PAUSE_BIT] ==
    $past(st_reg.advert[ANC_ADV_ASYM_BIT:ANC_ADV_PAUSE_BIT]))
    else $error("pause advertisement mismatch");

endmodule
`default_nettype wire

// [core/anc_pkg.sv]
// Constants, register map and types of the auto-negotiation control block
`default_nettype none
package anc_pkg;

  localparam logic [4:0] ANC_ADDR_CTRL = 5'h00;
  localparam logic [4:0] ANC_ADDR_STAT = 5'h01;
  localparam logic [4:0] ANC_ADDR_ADV = 5'h04;
  localparam logic [4:0] ANC_ADDR_PART = 5'h05;
  localparam logic [4:0] ANC_ADDR_EXP = 5'h06;
  localparam logic [4:0] ANC_ADDR_NPTX = 5'h07;

  localparam int ANC_CTRL_EN_BIT = 12;
  localparam int ANC_CTRL_RESTART_BIT = 9;
  localparam int ANC_STAT_DONE_BIT = 5;
  localparam int ANC_STAT_ABLE_BIT = 3;
  localparam int ANC_STAT_LINK_BIT = 2;
  localparam int ANC_ADV_PAUSE_BIT = 10;
  localparam int ANC_ADV_ASYM_BIT = 11;
  localparam int ANC_ADV_NP_BIT = 15;
  localparam int ANC_AB_10H_BIT = 5;
  localparam int ANC_AB_10F_BIT = 6;
  localparam int ANC_AB_100H_BIT = 7;
  localparam int ANC_AB_100F_BIT = 8;
  localparam int ANC_EXP_ABLE_BIT = 0;
  localparam int ANC_EXP_PAGE_BIT = 1;
  localparam int ANC_EXP_NPABLE_BIT = 2;
  localparam int ANC_EXP_FAULT_BIT = 4;

  localparam logic [4:0] ANC_SELECTOR = 5'h01;
  localparam logic [15:0] ANC_ADV_RESET = 16'h0de1;
  localparam logic [15:0] ANC_NPTX_RESET = 16'h2001;

  localparam int ANC_CLK_HZ = 50000000;
  localparam int ANC_BREAK_MS = 1200;
  localparam int ANC_BREAK_CYCLES = ANC_BREAK_MS * (ANC_CLK_HZ / 1000);

  typedef enum logic [2:0] {
    MODE_NONE, MODE_10H, MODE_10F, MODE_100H, MODE_100F,
    MODE_1000H, MODE_1000F
  } anc_mode_t;

  typedef enum logic [2:0] {
    ST_DISABLED, ST_BREAK, ST_ABILITY, ST_NEXTPG, ST_COMPLETE
  } anc_fsm_t;

  typedef struct packed {
    logic gigFull;
    logic gigHalf;
    logic multiport;
  } anc_gig_t;

  typedef struct packed {
    anc_fsm_t fsm;
    logic strapOff;
    logic anEnable;
    logic ctrlRestart;
    logic [15:0] advert;
    logic [15:0] partner;
    logic [15:0] nextPage;
    logic npLoaded;
    logic expAble;
    logic expPage;
    logic parFault;
    logic parMode;
    logic complete;
    logic linkSeen;
    logic [31:0] timer;
    logic flpActive;
    logic dataEnable;
    logic [15:0] txPage;
    anc_mode_t mode;
    logic isMaster;
    logic pauseValid;
    logic [15:0] rdData;
    logic rdValid;
  } anc_state_t;

endpackage
`default_nettype wire

// [verif/anc_link_partner.sv]
// Link partner model: answers local bursts with one page per request
`timescale 1ns/1ps
`default_nettype none
module anc_link_partner (
  input wire logic ref_clk,          // Core clock
  input wire logic flpActive,        // Local pulse bursts on
  input wire logic armPage,          // Request to send one page
  input wire logic [15:0] pageWord,  // Page word to send
  input wire logic [3:0] lagCycles,  // Extra wait, for slow answers
  output logic rxPageValid,          // Page received pulse
  output logic [15:0] rxPage         // Page word
);
  logic pending;
  logic [3:0] lag;
  initial begin
    pending = 1'b0;
    lag = 4'h0;
    rxPageValid = 1'b0;
    rxPage = 16'h0000;
  end
  always @(posedge ref_clk) begin
    rxPageValid <= 1'b0;
    // Word line inverts its last value every cycle outside a page
    rxPage <= ~rxPage;
    if (armPage) begin
      pending <= 1'b1;
      lag <= lagCycles;
    end else if (pending && flpActive) begin
      if (lag != 4'h0) begin
        lag <= lag - 4'h1;
      end else begin
        rxPageValid <= 1'b1;
        rxPage <= pageWord;
        pending <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/autoneg_control_status_bench.sv]
// Self-checking bench of the auto-negotiation control core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  n_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); \
  end end
module autoneg_control_status_bench;
  import anc_pkg::*;
  localparam int BRK = 10;
  logic ref_clk = 1'b0, srst = 1'b1, strapAnOff = 1'b0, linkUp = 1'b1;
  logic regWrEn = 1'b0, regRdEn = 1'b0, seedWins = 1'b0, armPage = 1'b0;
  logic linkGood10 = 1'b0, linkGood100 = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWrData = 16'h0000, pageWord = 16'h0000;
  logic [3:0] lagCycles = 4'h0;
  anc_gig_t localGig = '0, partnerGig = '0;
  logic [15:0] regRdData, rxPage, txPage, d, adv, pw;
  logic regRdValid, rxPageValid, flpActive, dataEnable, isMaster;
  logic pauseValid, expMaster;
  anc_mode_t mode, em;
  logic [31:0] r;
  int n_errors = 0, samples_checked = 0, n;

  anc_autoneg_core #(.BREAK_CYCLES(BRK)) DUT (.ref_clk, .srst,
    .strapAnOff, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
    .regRdValid, .rxPageValid, .rxPage, .linkGood10, .linkGood100,
    .linkUp, .localGig, .partnerGig, .seedWins, .flpActive, .dataEnable,
    .txPage, .mode, .isMaster, .pauseValid);
  anc_link_partner LP (.ref_clk, .flpActive, .armPage, .pageWord,
    .lagCycles, .rxPageValid, .rxPage);

  always #10 ref_clk = ~ref_clk;

  function automatic anc_mode_t exp_mode(logic [15:0] c);
    if (localGig.gigFull && partnerGig.gigFull) return MODE_1000F;
    if (localGig.gigHalf && partnerGig.gigHalf) return MODE_1000H;
    if (c[ANC_AB_100F_BIT]) return MODE_100F;
    if (c[ANC_AB_100H_BIT]) return MODE_100H;
    if (c[ANC_AB_10F_BIT]) return MODE_10F;
    if (c[ANC_AB_10H_BIT]) return MODE_10H;
    return MODE_NONE;
  endfunction

  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge ref_clk);
    regAddr = a;
    regWrData = v;
    regWrEn = 1'b1;
    @(negedge ref_clk);
    regWrEn = 1'b0;
  endtask

  task automatic rd(input logic [4:0] a);
    @(negedge ref_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge ref_clk);
    regRdEn = 1'b0;
    `CHK(regRdValid, 1'b1)
    d = regRdData;
  endtask

  task automatic pg(input logic [15:0] p, input logic [3:0] l);
    @(negedge ref_clk);
    pageWord = p;
    lagCycles = l;
    armPage = 1'b1;
    @(negedge ref_clk);
    armPage = 1'b0;
  endtask

  task automatic wait_flp();
    n = 0;
    while (flpActive !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  task automatic wait_done();
    for (int i = 0; i < 40; i++) begin
      rd(ANC_ADDR_STAT);
      if (d[ANC_STAT_DONE_BIT] === 1'b1) break;
    end
    `CHK(d[ANC_STAT_DONE_BIT], 1'b1)
  endtask

  // Restart and time the silent break before bursts come back
  task automatic rs(input logic [15:0] v);
    wr(ANC_ADDR_CTRL, v);
    repeat (2) @(negedge ref_clk);
    `CHK(dataEnable, 1'b0)
    `CHK(flpActive, 1'b0)
    wait_flp();
    `CHK(n >= BRK - 1 && n <= BRK + 3, 1'b1)
    rd(ANC_ADDR_CTRL);
    `CHK(d[ANC_CTRL_RESTART_BIT], 1'b0)
  endtask

  task automatic neg(input logic [15:0] a, input logic [15:0] p);
    wr(ANC_ADDR_ADV, a);
    rs(16'h1200);
    `CHK(txPage, a)
    pg(p, r[15:12]);
    wait_done();
    rd(ANC_ADDR_PART);
    `CHK(d, p)
    rd(ANC_ADDR_EXP);
    `CHK(d[ANC_EXP_ABLE_BIT], 1'b1)
    em = exp_mode(a & p);
    `CHK(mode, em)
    `CHK(pauseValid, em inside {MODE_10F, MODE_100F, MODE_1000F})
    if (em == MODE_1000F || em == MODE_1000H) begin
      expMaster = (localGig.multiport != partnerGig.multiport) ?
        localGig.multiport : seedWins;
      `CHK(isMaster, expMaster)
    end else begin
      `CHK(isMaster, 1'b0)
    end
  endtask

  initial begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(19));
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    rd(ANC_ADDR_ADV);
    `CHK(d, ANC_ADV_RESET)
    rd(ANC_ADDR_NPTX);
    `CHK(d, ANC_NPTX_RESET)
    rd(5'h03);
    `CHK(d, 16'h0000)
    rd(ANC_ADDR_STAT);
    `CHK(d[ANC_STAT_ABLE_BIT], 1'b1)
    wait_flp();
    `CHK(flpActive, 1'b1)
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      localGig = r[2:0];
      partnerGig = r[5:3];
      seedWins = r[6];
      adv = {4'h0, r[11:10], 1'b0, r[9:6], 5'h01};
      pw = {4'h0, r[17:16], 1'b0, r[21:18], 5'h01};
      if (i == 0) begin
        adv = 16'h0de1;
        pw = 16'h0de1;
        localGig = 3'b111;
        partnerGig = 3'b110;
      end
      neg(adv, pw);
    end
    localGig = '0;
    partnerGig = '0;
    rs(16'h1200);
    linkGood10 = 1'b1;
    linkGood100 = 1'b1;
    repeat (6) @(negedge ref_clk);
    rd(ANC_ADDR_EXP);
    `CHK(d[ANC_EXP_FAULT_BIT], 1'b1)
    for (int k = 0; k < 2; k++) begin
      linkGood10 = 1'b0;
      linkGood100 = 1'b0;
      rs(16'h1200);
      linkGood100 = k[0];
      linkGood10 = !k[0];
      wait_done();
      rd(ANC_ADDR_PART);
      `CHK(d, k[0] ? 16'h0081 : 16'h0021)
      rd(ANC_ADDR_EXP);
      `CHK(d[ANC_EXP_ABLE_BIT], 1'b0)
      `CHK(mode, k[0] ? MODE_100H : MODE_10H)
    end
    linkUp = 1'b0;
    linkGood100 = 1'b0;
    wait_flp();
    `CHK(n <= 4, 1'b1)
    rd(ANC_ADDR_EXP);
    `CHK(d[ANC_EXP_FAULT_BIT], 1'b1)
    rd(ANC_ADDR_STAT);
    `CHK(d[ANC_STAT_DONE_BIT], 1'b0)
    linkUp = 1'b1;
    wr(ANC_ADDR_NPTX, 16'h2345);
    wr(ANC_ADDR_ADV, 16'h8de1);
    rs(16'h1200);
    pg(16'h81e1, 4'h3);
    n = 0;
    while (txPage !== 16'h2345 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(txPage, 16'h2345)
    wr(ANC_ADDR_NPTX, 16'h2345);
    pg(16'h2001, 4'h0);
    wait_done();
    `CHK(mode, MODE_100F)
    wr(ANC_ADDR_CTRL, 16'h0000);
    repeat (2) @(negedge ref_clk);
    `CHK(dataEnable, 1'b1)
    `CHK(flpActive, 1'b0)
    rs(16'h1000);
    strapAnOff = 1'b1;
    srst = 1'b1;
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    rd(ANC_ADDR_STAT);
    `CHK(d[ANC_STAT_ABLE_BIT], 1'b0)
    wr(ANC_ADDR_CTRL, 16'h1000);
    repeat (BRK + 6) @(negedge ref_clk);
    `CHK(flpActive, 1'b0)
    rd(ANC_ADDR_CTRL);
    `CHK(d[ANC_CTRL_EN_BIT], 1'b0)
    tally_and_finish();
  end
endmodule
`default_nettype wire
